// ===== adcts_regs.svh
// Constants for the two-wire ADC slave and its conversion control.
// Assumes the includer sits in a design clocked at 100 MHz.
// Contract
// RL1 - Detect start and stop on the bus
// RL2 - Repeated start keeps bus active and mode
// RL3 - Receiver acks by holding SDA low, ninth
// RL4 - Master retries later after not-acknowledge
// RL5 - Respond only to the fixed slave address
// RL6 - Address LSB gives transfer direction
// RL7 - Ack matching address, then move data
// RL8 - Power-up uses fast/standard timing
// RL9 - Master code is nacked, enters high-speed
// RL10 - Master follows master code with repeated start
// RL11 - Stop returns high-speed to fast timing
// RL12 - Top bit picks setup or configuration
// RL13 - One or two bytes written, each acked
// RL14 - Read nack releases SDA for stop
// RL15 - Setup clock bit picks clocking, default internal
// RL16 - Internal: track at ninth fall, convert later
// RL17 - Internal: stretch SCL until results stored; code also releases SCL after CONV_CYC clocks with no result
// RL18 - Scan results stored back to back
// RL19 - Results read FIFO order, wrapping around
// RL20 - Skip reference pin when configured as reference
// RL21 - External: track at seventh fall of address
// RL22 - External: convert continuously until nack
// RL23 - Master keeps external conversions within 9ms
// RL24 - Bytes MSB first, SDA changes SCL low
`ifndef ADCTS_REGS_SVH
`define ADCTS_REGS_SVH
// ****************************************************************
// Addresses and codes
// ****************************************************************
`define ADCTS_ADDR_SMALL   7'h64
`define ADCTS_ADDR_LARGE   7'h65
`define ADCTS_HS_CODE_HI   5'h01
`define ADCTS_SETUP_RST    8'h80
`define ADCTS_CONFIG_RST   8'h01
// ****************************************************************
// Field positions
// ****************************************************************
`define ADCTS_REG_BIT      7
`define ADCTS_CLK_BIT      3
`define ADCTS_REFROLE_BIT  5
`define ADCTS_CFGRST_BIT   1
// ****************************************************************
// Timing
// ****************************************************************
`define ADCTS_CLK_MHZ      100
`define ADCTS_CONV_NS      7600
`define ADCTS_CONV_CYC     ((`ADCTS_CONV_NS * `ADCTS_CLK_MHZ) / 1000)
`define ADCTS_RAM_DEPTH    12
`endif

// ===== adcts_pkg.sv
// Types for the two-wire ADC slave.
// Assumes nothing beyond the constant header.
package adcts_pkg;
   // Bus protocol states
   typedef enum logic [2:0] {
      ADCTS_IDLE = 3'b000,
      ADCTS_ADDR = 3'b001,
      ADCTS_WR   = 3'b010,
      ADCTS_RD   = 3'b011,
      ADCTS_CONV = 3'b100,
      ADCTS_SKIP = 3'b101
   } adcts_state_e;
endpackage

// ===== adcts_fifo.sv
// Parameterised valid/ready FIFO for conversion samples.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module adcts_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst,
   // Fill side
   input  wire logic             i_valid,
   input  wire logic [WIDTH-1:0] i_data,
   output logic                  o_ready,
   // Drain side
   output logic                  o_valid,
   output logic [WIDTH-1:0]      o_data,
   input  wire logic             i_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];      // Storage
   logic [AW-1:0]    wp_r;               // Write pointer
   logic [AW-1:0]    rp_r;               // Read pointer
   logic [AW:0]      cnt_r;              // Occupancy
   logic             push;
   logic             pop;
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;
   assign o_ready = (cnt_r < (AW+1)'(DEPTH));  // Room for one more word, empty included
   assign o_valid = (cnt_r != '0);
   assign o_data  = mem_r[rp_r];
   // Storage write
   always_ff @(posedge i_clk_sys) begin
      if (push) begin
         mem_r[wp_r] <= i_data;
      end
   end
   // Pointers and count
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ===== adcts_slave.sv
// Two-wire slave of a multichannel 8-bit ADC with conversion sequencing.
// Assumes SCL/SDA already synchronous to i_clk_sys; pads resolve enables.
`timescale 1ns/1ps
`include "adcts_regs.svh"
module adcts_slave
   import adcts_pkg::*;
#(
   parameter logic       LARGE_VARIANT = 1'b0,
   parameter int         CONV_CYC      = `ADCTS_CONV_CYC
) (
   // Clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst,
   // Two-wire pins
   input  wire logic       i_scl,
   output logic            o_scl_oe,
   input  wire logic       i_sda,
   output logic            o_sda_oe,
   output logic            o_sda_out,
   // Converter sample stream
   input  wire logic       i_smp_valid,
   input  wire logic [7:0] i_smp_data,
   output logic            o_smp_ready,
   // Converter control
   output logic            o_conv_start,
   output logic [3:0]      o_conv_chan,
   output logic [7:0]      o_setup,
   output logic [7:0]      o_config,
   output logic            o_hs_mode,
   output logic            o_busy
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   localparam logic [6:0] MY_ADDR = LARGE_VARIANT ? `ADCTS_ADDR_LARGE : `ADCTS_ADDR_SMALL;
   localparam logic [3:0] NCH     = LARGE_VARIANT ? 4'hc : 4'h4;
   localparam logic [3:0] REF_CH  = NCH - 4'h1;     // Shared input/ref pin index
   localparam logic [3:0] DEPTH   = LARGE_VARIANT ? 4'hc : 4'h8;
   adcts_state_e st_r;                 // Protocol state
   logic         scl_d_r;              // Previous SCL
   logic         sda_d_r;              // Previous SDA
   logic [3:0]   bit_r;                // Bit count in byte
   logic [7:0]   sh_r;                 // Shift register
   logic         rd_r;                 // Direction of transfer
   logic         ack_r;                // In ack slot
   logic [7:0]   ram_r [12];           // Result memory
   logic [3:0]   ram_n_r;              // Stored results
   logic [3:0]   ram_rp_r;             // Read pointer
   logic [3:0]   chan_r;               // Scan channel
   logic [15:0]  tmo_r;                // Conversion deadline counter
   logic         fifo_v;
   logic [7:0]   fifo_d;
   logic         fifo_rdy;
   logic         fall;
   logic         rise;
   logic         start_c;
   logic         stop_c;
   logic         ext_clk;
   logic         ref_skip;
   logic [3:0]   last_ch;
   logic [7:0]   tx_byte;
   logic [3:0]   chan_nxt;             // Next scan channel, shared pin skipped
   assign fall     = scl_d_r && !i_scl;
   assign rise     = !scl_d_r && i_scl;
   assign start_c  = i_scl && scl_d_r && sda_d_r && !i_sda;    // [RL1]
   assign stop_c   = i_scl && scl_d_r && !sda_d_r && i_sda;    // [RL1]
   assign ext_clk  = o_setup[`ADCTS_CLK_BIT];                  // [RL15]
   assign ref_skip = o_setup[`ADCTS_REFROLE_BIT];              // [RL20]
   assign last_ch  = o_config[4:1];
   assign tx_byte  = ext_clk ? fifo_d : ram_r[ram_rp_r];
   assign chan_nxt = (ref_skip && chan_r + 4'h1 == REF_CH) ? chan_r + 4'h2 : chan_r + 4'h1;  // [RL20]
   // ****************************************************************
   // Sample FIFO
   // ****************************************************************
   adcts_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_valid   (i_smp_valid && o_smp_ready),
      .i_data    (i_smp_data),
      .o_ready   (fifo_rdy),
      .o_valid   (fifo_v),
      .o_data    (fifo_d),
      .i_ready   (st_r == ADCTS_CONV || (st_r == ADCTS_RD && ack_r && rise && !i_sda && ext_clk))
   );
   // Ready back to converter
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_smp_ready <= 1'b0;
      end else begin
         // Ready drops for a cycle after each accepted word, so the late
         // registered view can never promise room the FIFO no longer has
         o_smp_ready <= fifo_rdy && !(i_smp_valid && o_smp_ready);
      end
   end
   // ****************************************************************
   // Line history
   // ****************************************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= i_scl;
         sda_d_r <= i_sda;
      end
   end
   // ****************************************************************
   // Protocol engine
   // ****************************************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st_r         <= ADCTS_IDLE;
         bit_r        <= '0;
         sh_r         <= '0;
         rd_r         <= 1'b0;
         ack_r        <= 1'b0;
         o_sda_oe     <= 1'b0;
         o_sda_out    <= 1'b0;
         o_scl_oe     <= 1'b0;
         o_hs_mode    <= 1'b0;                                  // [RL8]
         o_setup      <= `ADCTS_SETUP_RST;                      // [RL15]
         o_config     <= `ADCTS_CONFIG_RST;
         ram_n_r      <= '0;
         ram_rp_r     <= '0;
         chan_r       <= '0;
         tmo_r        <= '0;
         o_conv_start <= 1'b0;
         o_conv_chan  <= '0;
         o_busy       <= 1'b0;
      end else begin
         o_conv_start <= 1'b0;
         if (stop_c) begin
            // Stop frees the line and drops high-speed
            st_r      <= ADCTS_IDLE;
            o_sda_oe  <= 1'b0;
            o_scl_oe  <= 1'b0;
            o_busy    <= 1'b0;
            o_hs_mode <= 1'b0;                                  // [RL11]
         end else if (start_c) begin
            // Start or repeated start; mode kept
            st_r     <= ADCTS_ADDR;                             // [RL2]
            bit_r    <= '0;
            ack_r    <= 1'b0;
            o_sda_oe <= 1'b0;
            o_busy   <= 1'b1;
         end else begin
            case (st_r)
               ADCTS_IDLE: begin
                  o_sda_oe <= 1'b0;
               end
               ADCTS_ADDR, ADCTS_WR, ADCTS_SKIP: begin
                  // Receive byte MSB first on rising edges
                  if (rise && !ack_r) begin
                     sh_r  <= {sh_r[6:0], i_sda};               // [RL24]
                     bit_r <= bit_r + 4'h1;
                  end
                  // External clock tracking starts on seventh fall
                  if (fall && st_r == ADCTS_ADDR && bit_r == 4'h7 && ext_clk
                      && sh_r[6:0] == MY_ADDR) begin
                     o_conv_start <= 1'b1;                      // [RL21]
                     o_conv_chan  <= 4'h0;
                     chan_r       <= 4'h0;
                  end
                  if (fall && bit_r == 4'h8 && !ack_r) begin
                     ack_r <= 1'b1;
                     if (st_r == ADCTS_ADDR && sh_r[7:1] == MY_ADDR) begin
                        o_sda_oe  <= 1'b1;                      // [RL7] [RL3]
                        o_sda_out <= 1'b0;
                        rd_r      <= sh_r[0];                   // [RL6]
                     end else if (st_r == ADCTS_ADDR && sh_r[7:3] == `ADCTS_HS_CODE_HI) begin
                        o_sda_oe  <= 1'b0;                      // [RL9]
                        o_hs_mode <= 1'b1;
                        st_r      <= ADCTS_SKIP;
                     end else if (st_r == ADCTS_WR) begin
                        o_sda_oe  <= 1'b1;                      // [RL13]
                        o_sda_out <= 1'b0;
                        if (sh_r[`ADCTS_REG_BIT]) begin         // [RL12]
                           o_setup <= sh_r;
                           if (!sh_r[`ADCTS_CFGRST_BIT]) begin
                              o_config <= `ADCTS_CONFIG_RST;
                           end
                        end else begin
                           o_config <= sh_r;
                        end
                     end else begin
                        st_r <= ADCTS_SKIP;                     // [RL5]
                     end
                  end else if (fall && ack_r) begin
                     // End of ack slot
                     ack_r    <= 1'b0;
                     bit_r    <= '0;
                     o_sda_oe <= 1'b0;
                     if (st_r == ADCTS_ADDR && o_sda_oe) begin
                        if (!rd_r) begin
                           st_r <= ADCTS_WR;
                        end else if (!ext_clk) begin
                           // Ninth fall: stretch and scan
                           st_r         <= ADCTS_CONV;          // [RL16]
                           o_scl_oe     <= 1'b1;                // [RL17]
                           ram_n_r      <= '0;
                           ram_rp_r     <= '0;
                           chan_r       <= 4'h0;
                           o_conv_start <= 1'b1;
                           o_conv_chan  <= 4'h0;
                           tmo_r        <= '0;
                        end else begin
                           st_r      <= ADCTS_RD;               // [RL22]
                           o_sda_oe  <= !fifo_d[7];
                           o_sda_out <= 1'b0;
                           bit_r     <= 4'h1;
                        end
                     end else if (st_r == ADCTS_SKIP) begin
                        st_r <= ADCTS_IDLE;
                     end
                  end
               end
               ADCTS_CONV: begin
                  // Store each result, then move to next channel
                  tmo_r <= tmo_r + 16'h1;
                  if (fifo_v) begin
                     ram_r[ram_n_r] <= fifo_d;                  // [RL18]
                     ram_n_r        <= ram_n_r + 4'h1;
                     tmo_r          <= '0;
                     if (chan_r >= last_ch || chan_nxt > last_ch || ram_n_r + 4'h1 >= DEPTH) begin
                        st_r      <= ADCTS_RD;                  // [RL17]
                        o_scl_oe  <= 1'b0;
                        o_sda_oe  <= (ram_n_r == 4'h0) ? !fifo_d[7] : !ram_r[0][7];
                        o_sda_out <= 1'b0;
                        bit_r     <= 4'h1;
                     end else begin
                        chan_r       <= chan_nxt;               // [RL20]
                        o_conv_start <= 1'b1;
                        o_conv_chan  <= chan_nxt;
                     end
                  end else if (tmo_r == 16'(CONV_CYC)) begin
                     // Converter silent: release the line anyway
                     st_r     <= ADCTS_RD;
                     o_scl_oe <= 1'b0;
                     bit_r    <= 4'h1;
                  end
               end
               ADCTS_RD: begin
                  // Drive data bits on falling edges
                  if (fall && !ack_r) begin
                     if (bit_r == 4'h8) begin
                        ack_r    <= 1'b1;
                        o_sda_oe <= 1'b0;
                     end else begin
                        o_sda_oe <= !tx_byte[3'(7 - bit_r)];     // [RL24]
                        bit_r    <= bit_r + 4'h1;
                     end
                  end else if (rise && ack_r) begin
                     if (i_sda) begin
                        st_r <= ADCTS_IDLE;                     // [RL14]
                     end else if (!ext_clk) begin
                        ram_rp_r <= (ram_rp_r + 4'h1 >= ram_n_r) ? 4'h0 : ram_rp_r + 4'h1;  // [RL19]
                     end else begin
                        // Next channel of the scan, back to the first after the last
                        o_conv_start <= 1'b1;                   // [RL22]
                        chan_r       <= (chan_nxt > last_ch) ? 4'h0 : chan_nxt;
                        o_conv_chan  <= (chan_nxt > last_ch) ? 4'h0 : chan_nxt;
                     end
                  end else if (fall && ack_r) begin
                     ack_r    <= 1'b0;
                     bit_r    <= 4'h1;
                     o_sda_oe <= !tx_byte[7];
                  end
               end
               default: begin
                  st_r <= ADCTS_IDLE;
               end
            endcase
         end
      end
   end
   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_hs_stop_exit: assert property (@(posedge i_clk_sys) disable iff (i_rst)  // [RL11]
      stop_c |=> !o_hs_mode) else $error("high-speed kept after stop");
   chk_stop_frees_scl: assert property (@(posedge i_clk_sys) disable iff (i_rst)  // [RL17]
      stop_c |=> !o_scl_oe) else $error("SCL held after stop");
   chk_start_busy: assert property (@(posedge i_clk_sys) disable iff (i_rst)  // [RL1]
      start_c && !stop_c |=> o_busy && st_r == ADCTS_ADDR) else $error("start missed");
   chk_rs_keeps_hs: assert property (@(posedge i_clk_sys) disable iff (i_rst)  // [RL2]
      start_c && o_hs_mode |=> o_hs_mode) else $error("repeated start dropped mode");
   chk_idle_no_sda: assert property (@(posedge i_clk_sys) disable iff (i_rst)  // [RL5]
      st_r == ADCTS_IDLE && $past(st_r) == ADCTS_IDLE |-> !o_sda_oe) else $error("idle drives SDA");
   chk_conv_stretch: assert property (@(posedge i_clk_sys) disable iff (i_rst)  // [RL17]
      st_r == ADCTS_CONV |-> o_scl_oe) else $error("no stretch while converting");
   chk_nack_release: assert property (@(posedge i_clk_sys) disable iff (i_rst)  // [RL14]
      st_r == ADCTS_RD && ack_r && rise && i_sda && !stop_c && !start_c |=> !o_sda_oe)
      else $error("SDA held after nack");
   chk_hs_enter: assert property (@(posedge i_clk_sys) disable iff (i_rst)  // [RL9]
      $rose(o_hs_mode) |-> !o_sda_oe && st_r == ADCTS_SKIP) else $error("master code acked");
   chk_ptr_range: assert property (@(posedge i_clk_sys) disable iff (i_rst)  // [RL19]
      ram_n_r != 4'h0 |-> ram_rp_r < ram_n_r) else $error("read pointer past results");
   cov_write: cover property (@(posedge i_clk_sys) st_r == ADCTS_WR);
   cov_conv: cover property (@(posedge i_clk_sys) st_r == ADCTS_CONV ##1 st_r == ADCTS_RD);
   cov_hs: cover property (@(posedge i_clk_sys) $rose(o_hs_mode));
endmodule

// ===== adcts_mstr.sv
// Behavioural two-wire bus master that faces the ADC slave.
// Assumes open-drain lines with pull-ups resolved by the testbench.
`timescale 1ns/1ps
module adcts_mstr #(
   parameter int HALF = 5   // Clocks per SCL half period, far inside the 9ms limit
) (
   // Clock
   input  wire logic i_clk_sys,
   // Resolved bus levels
   input  wire logic i_scl,
   input  wire logic i_sda,
   // Master drive: 0 pulls low, 1 releases
   output logic      o_scl_drv,
   output logic      o_sda_drv
);
   int to_cnt = 0;   // Stretch waits that ran out

   // ****************************************
   // Bus primitives
   // ****************************************
   initial begin
      o_scl_drv = 1'b1;
      o_sda_drv = 1'b1;
   end

   task automatic half();
      repeat (HALF) @(negedge i_clk_sys);
   endtask

   // Release SCL and wait, bounded, through any stretch
   task automatic scl_up();
      int n;
      n = 0;
      o_scl_drv = 1'b1;
      do begin
         @(negedge i_clk_sys);
         n++;
      end while (i_scl !== 1'b1 && n < 4000);
      if (n >= 4000) begin
         to_cnt++;
      end
      half();
   endtask

   // Start, also serving as repeated start
   task automatic start_cond();
      o_sda_drv = 1'b1;
      half();
      scl_up();
      o_sda_drv = 1'b0;
      half();
      o_scl_drv = 1'b0;
   endtask

   // Stop: SDA rises while SCL high
   task automatic stop_cond();
      @(negedge i_clk_sys);
      o_sda_drv = 1'b0;
      half();
      scl_up();
      o_sda_drv = 1'b1;
      half();
   endtask

   // One bit; SDA changes only while SCL is low
   task automatic bit_xfer(input logic b, output logic r);
      @(negedge i_clk_sys);
      o_sda_drv = b;
      half();
      scl_up();
      r = i_sda;
      o_scl_drv = 1'b0;
   endtask

   // Byte out, MSB first, then sample the ninth-pulse ack
   task automatic byte_wr(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], r);
      end
      bit_xfer(1'b1, r);
      ack = ~r;
   endtask

   // Byte in, then ack to go on or nack to finish
   task automatic byte_rd(input logic ack_in, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, d[i]);
      end
      bit_xfer(~ack_in, r);
   endtask
endmodule

// ===== adc_two_wire_slave_conv_control_tb_top.sv
// Self-checking bench for the two-wire ADC slave and its sample FIFO.
// Assumes a 100 MHz clock and a behavioural converter answering each request.
`timescale 1ns/1ps
module adc_two_wire_slave_conv_control_tb_top;
   import adcts_pkg::*;
   logic       i_clk_sys;
   logic       i_rst        = 1'b1;
   logic       scl_drv, sda_drv;              // Master drive levels
   logic       o_scl_oe, o_sda_oe, o_sda_out; // Slave pin drives
   logic       smp_valid    = 1'b0;           // Converter result stream
   logic [7:0] smp_data     = 8'h00;
   logic       o_smp_ready, o_conv_start, o_hs_mode, o_busy, took = 1'b0;
   logic [3:0] o_conv_chan;
   logic [7:0] o_setup, o_config;
   logic       stretch_seen = 1'b0;
   int         cnv_cnt      = 0;
   int         dly          = 0;
   int         error_cnt    = 0;
   int         checks       = 0;
   logic [7:0] d8;                            // Byte read by the master
   int         n;
   // Open-drain lines with pull-ups
   wire        scl = scl_drv & ~o_scl_oe;
   wire        sda = sda_drv & ~(o_sda_oe & ~o_sda_out);

   // ****************************************
   // Instances
   // ****************************************
   adcts_slave #(.LARGE_VARIANT(1'b0), .CONV_CYC(50)) u_adcts_slave (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_scl(scl), .o_scl_oe(o_scl_oe), .i_sda(sda),
      .o_sda_oe(o_sda_oe), .o_sda_out(o_sda_out), .i_smp_valid(smp_valid), .i_smp_data(smp_data),
      .o_smp_ready(o_smp_ready), .o_conv_start(o_conv_start), .o_conv_chan(o_conv_chan),
      .o_setup(o_setup), .o_config(o_config), .o_hs_mode(o_hs_mode), .o_busy(o_busy));
   adcts_mstr u_adcts_mstr (.i_clk_sys(i_clk_sys), .i_scl(scl), .i_sda(sda),
      .o_scl_drv(scl_drv), .o_sda_drv(sda_drv));

   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   // Converter: answers each request 4 clocks later with 0xa0 plus channel
   always @(posedge i_clk_sys) begin
      took <= smp_valid & o_smp_ready;
   end
   always @(negedge i_clk_sys) begin
      if (o_scl_oe === 1'b1) begin
         stretch_seen <= 1'b1;
      end
      if (took) begin
         smp_valid <= 1'b0;
      end
      if (dly > 0) begin
         dly <= dly - 1;
         smp_valid <= (dly == 1) ? 1'b1 : smp_valid;
      end
      if (o_conv_start === 1'b1) begin
         cnv_cnt  <= cnv_cnt + 1;
         dly      <= 4;
         smp_data <= 8'ha0 + {4'h0, o_conv_chan};
      end
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic addr(input logic [7:0] b, input logic exp_ack);
      logic a;
      u_adcts_mstr.start_cond();
      u_adcts_mstr.byte_wr(b, a);
      chk({7'h00, a}, {7'h00, exp_ack});
   endtask

   task automatic wr(input logic [7:0] b);
      logic a;
      u_adcts_mstr.byte_wr(b, a);
      chk({7'h00, a}, 8'h01);
   endtask

   // Internal-clock read of n results plus one wrapped byte
   task automatic scan_read(input int n);
      logic [7:0] d;
      cnv_cnt = 0;
      stretch_seen = 1'b0;
      addr(8'hc9, 1'b1);
      for (int i = 0; i <= n; i++) begin
         u_adcts_mstr.byte_rd(i < n, d);
         chk(d, 8'ha0 + 8'(i % n));
      end
      repeat (3) @(negedge i_clk_sys);
      chk({7'h00, o_sda_oe}, 8'h00);
      u_adcts_mstr.stop_cond();
      chk(8'(cnv_cnt), 8'(n));
      chk({7'h00, stretch_seen}, 8'h01);
   endtask

   task automatic finish_test();
      error_cnt += u_adcts_mstr.to_cnt;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge i_clk_sys);
      error_cnt++;
      finish_test();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (10) @(negedge i_clk_sys);
      i_rst = 1'b0;
      @(negedge i_clk_sys);
      chk(o_setup, 8'h80);
      chk(o_config, 8'h01);
      chk({7'h00, o_hs_mode}, 8'h00);
      chk({6'h00, o_scl_oe, o_sda_oe}, 8'h00);
      addr(8'hca, 1'b0);
      u_adcts_mstr.stop_cond();
      addr(8'hc8, 1'b1);
      chk({7'h00, o_busy}, 8'h01);
      wr(8'h06);
      wr(8'h82);
      u_adcts_mstr.stop_cond();
      chk(o_config, 8'h06);
      chk(o_setup, 8'h82);
      scan_read(4);
      addr(8'hc8, 1'b1);
      wr(8'ha2);
      u_adcts_mstr.stop_cond();
      scan_read(3);
      addr(8'h0d, 1'b0);
      chk({7'h00, o_hs_mode}, 8'h01);
      addr(8'hc8, 1'b1);
      wr(8'h80);
      chk({7'h00, o_hs_mode}, 8'h01);
      u_adcts_mstr.stop_cond();
      chk({7'h00, o_hs_mode}, 8'h00);
      chk(o_config, 8'h01);
      addr(8'hc8, 1'b1);
      wr(8'h8a);
      u_adcts_mstr.stop_cond();
      cnv_cnt = 0;
      stretch_seen = 1'b0;
      addr(8'hc9, 1'b1);
      u_adcts_mstr.byte_rd(1'b1, d8);
      chk(d8, 8'ha0);
      u_adcts_mstr.byte_rd(1'b0, d8);
      chk(d8, 8'ha0);
      u_adcts_mstr.stop_cond();
      chk({7'h00, stretch_seen}, 8'h00);
      chk({7'h00, cnv_cnt > 0}, 8'h01);
      // FIFO: fill behind the idle slave; one word is left from the last read
      n = 0;
      for (int k = 0; k < 30; k++) begin
         @(negedge i_clk_sys);
         if (took === 1'b1) begin
            n++;
         end else if (smp_valid !== 1'b1) begin
            smp_data  <= 8'h10 + 8'(n);
            smp_valid <= 1'b1;
         end
      end
      @(negedge i_clk_sys);
      smp_valid <= 1'b0;
      chk(8'(n), 8'h07);
      chk({7'h00, o_smp_ready}, 8'h00);
      // Drain in order through external-clock reads
      addr(8'hc9, 1'b1);
      for (int k = 0; k < 8; k++) begin
         u_adcts_mstr.byte_rd(k < 7, d8);
         chk(d8, (k == 0) ? 8'ha0 : 8'h0f + 8'(k));
      end
      u_adcts_mstr.stop_cond();
      chk({7'h00, o_busy}, 8'h00);
      finish_test();
   end
endmodule
